/* File: design/eadec_pkg.sv */
package eadec_pkg;
	localparam logic [1:0] EADEC_FORM_MEM0  = 2'h0;
	localparam logic [1:0] EADEC_FORM_DISP8 = 2'h1;
	localparam logic [1:0] EADEC_FORM_DISPW = 2'h2;
	localparam logic [1:0] EADEC_FORM_REG   = 2'h3;
	localparam logic [2:0] EADEC_LOC_SIB    = 3'h4;
	localparam logic [2:0] EADEC_LOC_DIR32  = 3'h5;
	localparam logic [2:0] EADEC_LOC_DIR16  = 3'h6;
	localparam logic [2:0] EADEC_REG_SP     = 3'h4;
	localparam logic [2:0] EADEC_REG_BP     = 3'h5;
	localparam logic [2:0] EADEC_REG_SI     = 3'h6;
	localparam logic [2:0] EADEC_REG_DI     = 3'h7;
	localparam logic [2:0] EADEC_REG_BX     = 3'h3;
	localparam logic [2:0] EADEC_NO_INDEX   = 3'h4;
	localparam int EADEC_MODRM_POS_FORM     = 6;
	localparam int EADEC_MODRM_POS_REG      = 3;
	localparam logic [1:0] EADEC_SEG_DATA   = 2'h3;
	localparam logic [1:0] EADEC_SEG_STACK  = 2'h2;
	localparam logic [2:0] EADEC_DISP_NONE  = 3'h0;
	localparam logic [2:0] EADEC_DISP_BYTE  = 3'h1;
	localparam logic [2:0] EADEC_DISP_HALF  = 3'h2;
	localparam logic [2:0] EADEC_DISP_LONG  = 3'h4;
	// Operand width codes for a selected register
	typedef enum logic [1:0] {
		EADEC_OPW_BYTE = 2'h0,
		EADEC_OPW_HALF = 2'h1,
		EADEC_OPW_LONG = 2'h3
	} eadec_opw_e;
endpackage

/* File: design/eadec_regsel.sv */
`timescale 1ns/1ps
module eadec_regsel
	import eadec_pkg::*;
(
	// Register code and sizing
	input  wire logic [2:0]       code_in,
	input  wire logic             width_in,
	input  wire logic             data32_in,
	// Selected register
	output logic      [2:0]       reg_num_out,
	output logic                  reg_high_byte_out,
	output eadec_pkg::eadec_opw_e reg_width_out
);
	always_comb
	begin
		// Byte regs: codes 4..7 are high bytes of regs 0..3
		if (!width_in)
		begin
			reg_num_out       = {1'b0, code_in[1:0]};
			reg_high_byte_out = code_in[2];
			reg_width_out     = EADEC_OPW_BYTE;
		end
		else
		begin
			reg_num_out       = code_in;
			reg_high_byte_out = 1'b0;
			reg_width_out     = data32_in ? EADEC_OPW_LONG
				: EADEC_OPW_HALF;
		end
	end
endmodule // eadec_regsel

/* File: design/effective_address_decoder.sv */
`timescale 1ns/1ps
module effective_address_decoder
	import eadec_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Addressing bytes from prefetch
	input  wire logic             valid_in,
	input  wire logic [7:0]       modrm_in,
	input  wire logic [7:0]       sib_in,
	input  wire logic [31:0]      disp_in,
	input  wire logic             addr32_in,
	input  wire logic             data32_in,
	input  wire logic             width_in,
	// Effective-address recipe
	output logic                  valid_out,
	output logic                  is_reg_out,
	output logic                  sib_used_out,
	output logic                  base_en_out,
	output logic [2:0]            base_reg_out,
	output logic                  index_en_out,
	output logic [2:0]            index_reg_out,
	output logic [1:0]            scale_out,
	output logic [2:0]            disp_bytes_out,
	output logic [31:0]           disp_out,
	output logic [1:0]            segment_out,
	output logic [2:0]            bytes_used_out,
	// Register operands
	output logic [2:0]            rm_reg_out,
	output logic                  rm_high_out,
	output eadec_pkg::eadec_opw_e rm_width_out,
	output logic [2:0]            field_reg_out,
	output logic                  field_high_out,
	output eadec_pkg::eadec_opw_e field_width_out
);
	import eadec_pkg::*;

	typedef struct packed {
		logic             valid;
		logic             is_reg;
		logic             sib_used;
		logic             base_en;
		logic [2:0]       base_reg;
		logic             index_en;
		logic [2:0]       index_reg;
		logic [1:0]       scale;
		logic [2:0]       disp_bytes;
		logic [31:0]      disp;
		logic [1:0]       segment;
		logic [2:0]       bytes_used;
		logic [2:0]       rm_reg;
		logic             rm_high;
		eadec_opw_e       rm_width;
		logic [2:0]       field_reg;
		logic             field_high;
		eadec_opw_e       field_width;
	} eadec_state_s;

	eadec_state_s state_r;
	eadec_state_s state_nxt;

	logic [1:0]  form;
	logic [2:0]  loc;
	logic [2:0]  sib_base;
	logic [2:0]  sib_index;
	logic [2:0]  rm_num;
	logic        rm_high;
	eadec_opw_e  rm_width;
	logic [2:0]  fd_num;
	logic        fd_high;
	eadec_opw_e  fd_width;

	assign form      = modrm_in[7:EADEC_MODRM_POS_FORM];
	assign loc       = modrm_in[2:0];
	assign sib_base  = sib_in[2:0];
	assign sib_index = sib_in[5:3];

	eadec_regsel u_rm_sel (
		.code_in           (loc),
		.width_in          (width_in),
		.data32_in         (data32_in),
		.reg_num_out       (rm_num),
		.reg_high_byte_out (rm_high),
		.reg_width_out     (rm_width)
	);

	// Same map as the locator in form 11
	eadec_regsel u_field_sel (
		.code_in           (modrm_in[5:EADEC_MODRM_POS_REG]),
		.width_in          (width_in),
		.data32_in         (data32_in),
		.reg_num_out       (fd_num),
		.reg_high_byte_out (fd_high),
		.reg_width_out     (fd_width)
	);

	// Displacement width for a given form and address size
	function automatic logic [2:0] disp_len(input logic [1:0] f,
		input logic a32);
		if (f == EADEC_FORM_DISP8)
			disp_len = EADEC_DISP_BYTE;
		else if (f == EADEC_FORM_DISPW)
			disp_len = a32 ? EADEC_DISP_LONG : EADEC_DISP_HALF;
		else
			disp_len = EADEC_DISP_NONE;
	endfunction

	always_comb
	begin
		state_nxt            = '0;
		state_nxt.valid      = valid_in;
		state_nxt.segment    = EADEC_SEG_DATA;
		state_nxt.rm_reg     = rm_num;
		state_nxt.rm_high    = rm_high;
		state_nxt.rm_width   = rm_width;
		state_nxt.field_reg  = fd_num;
		state_nxt.field_high = fd_high;
		state_nxt.field_width = fd_width;
		state_nxt.disp_bytes = disp_len(form, addr32_in);
		if (form == EADEC_FORM_REG)
		begin
			state_nxt.is_reg = 1'b1;
		end
		else if (!addr32_in)
		begin
			// 16-bit tables; regs named by 16-bit numbering
			state_nxt.base_en  = 1'b1;
			state_nxt.index_en = 1'b1;
			case (loc)
				3'h0: {state_nxt.base_reg, state_nxt.index_reg} =
					{EADEC_REG_BX, EADEC_REG_SI};
				3'h1: {state_nxt.base_reg, state_nxt.index_reg} =
					{EADEC_REG_BX, EADEC_REG_DI};
				3'h2: {state_nxt.base_reg, state_nxt.index_reg} =
					{EADEC_REG_BP, EADEC_REG_SI};
				3'h3: {state_nxt.base_reg, state_nxt.index_reg} =
					{EADEC_REG_BP, EADEC_REG_DI};
				3'h4:
				begin
					state_nxt.base_reg = EADEC_REG_SI;
					state_nxt.index_en = 1'b0;
				end
				3'h5:
				begin
					state_nxt.base_reg = EADEC_REG_DI;
					state_nxt.index_en = 1'b0;
				end
				3'h6:
				begin
					state_nxt.base_reg = EADEC_REG_BP;
					state_nxt.index_en = 1'b0;
				end
				default:
				begin
					state_nxt.base_reg = EADEC_REG_BX;
					state_nxt.index_en = 1'b0;
				end
			endcase
			if (loc == EADEC_LOC_DIR16 && form == EADEC_FORM_MEM0)
			begin
				state_nxt.base_en    = 1'b0;
				state_nxt.disp_bytes = EADEC_DISP_HALF;
			end
			else if (state_nxt.base_reg == EADEC_REG_BP)
				state_nxt.segment = EADEC_SEG_STACK;
		end
		else if (loc == EADEC_LOC_SIB)
		begin
			state_nxt.sib_used  = 1'b1;
			state_nxt.scale     = sib_in[7:6];
			state_nxt.index_reg = sib_index;
			// Scale with no index is undefined; index is just dropped
			state_nxt.index_en  = (sib_index != EADEC_NO_INDEX);
			state_nxt.base_reg  = sib_base;
			state_nxt.base_en   = 1'b1;
			if (form == EADEC_FORM_MEM0 && sib_base == EADEC_LOC_DIR32)
			begin
				state_nxt.base_en    = 1'b0;
				state_nxt.disp_bytes = EADEC_DISP_LONG;
			end
			else if (sib_base == EADEC_REG_SP ||
				(sib_base == EADEC_REG_BP && form != EADEC_FORM_MEM0))
				state_nxt.segment = EADEC_SEG_STACK;
		end
		else
		begin
			state_nxt.base_reg = loc;
			state_nxt.base_en  = 1'b1;
			if (loc == EADEC_LOC_DIR32)
			begin
				if (form == EADEC_FORM_MEM0)
				begin
					state_nxt.base_en    = 1'b0;
					state_nxt.disp_bytes = EADEC_DISP_LONG;
				end
				else
					state_nxt.segment = EADEC_SEG_STACK;
			end
		end
		// Sign-extend byte form; wider forms take the bytes as given
		case (state_nxt.disp_bytes)
			EADEC_DISP_BYTE: state_nxt.disp = {{24{disp_in[7]}},
				disp_in[7:0]};
			EADEC_DISP_HALF: state_nxt.disp = {16'h0000, disp_in[15:0]};
			EADEC_DISP_LONG: state_nxt.disp = disp_in;
			default:         state_nxt.disp = 32'h0000_0000;
		endcase
		state_nxt.bytes_used = 3'h1 + {2'b00, state_nxt.sib_used}
			+ state_nxt.disp_bytes;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign valid_out       = state_r.valid;
	assign is_reg_out      = state_r.is_reg;
	assign sib_used_out    = state_r.sib_used;
	assign base_en_out     = state_r.base_en;
	assign base_reg_out    = state_r.base_reg;
	assign index_en_out    = state_r.index_en;
	assign index_reg_out   = state_r.index_reg;
	assign scale_out       = state_r.scale;
	assign disp_bytes_out  = state_r.disp_bytes;
	assign disp_out        = state_r.disp;
	assign segment_out     = state_r.segment;
	assign bytes_used_out  = state_r.bytes_used;
	assign rm_reg_out      = state_r.rm_reg;
	assign rm_high_out     = state_r.rm_high;
	assign rm_width_out    = state_r.rm_width;
	assign field_reg_out   = state_r.field_reg;
	assign field_high_out  = state_r.field_high;
	assign field_width_out = state_r.field_width;

	a_sib_presence: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(addr32_in && modrm_in[7:6] != 2'h3 && modrm_in[2:0] == 3'h4)
		|=> (sib_used_out && !is_reg_out))
		else $error("index byte missing for locator 100");
	a_direct16_seg: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(!addr32_in && modrm_in == 8'h06) |=> (!base_en_out &&
		segment_out == EADEC_SEG_DATA && disp_bytes_out == 3'h2))
		else $error("direct 16-bit address decoded wrong");
	a_bp_stack_seg: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(!addr32_in && modrm_in[7:6] != 2'h3 && modrm_in[2:1] == 2'h1)
		|=> segment_out == EADEC_SEG_STACK)
		else $error("frame based 16-bit form lost stack segment");
	a_byte_disp_ext: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(disp_bytes_out == 3'h1) |-> disp_out[31:8] == {24{disp_out[7]}})
		else $error("byte displacement not sign-extended");
	a_no_index_sp: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(addr32_in && modrm_in[7:6] != 2'h3 && modrm_in[2:0] == 3'h4 &&
		sib_in[5:3] == 3'h4) |=> !index_en_out)
		else $error("stack pointer used as index");
	a_direct32_sib: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(addr32_in && modrm_in[7:6] == 2'h0 && modrm_in[2:0] == 3'h4 &&
		sib_in[2:0] == 3'h5) |=> (!base_en_out && bytes_used_out == 3'h6))
		else $error("no-base index form decoded wrong");
	// Outputs are all zero just after reset, so skip that first edge
	a_byte_count: assert property (
		@(posedge clk_in) disable iff (rst_in)
		!$past(rst_in) |-> bytes_used_out ==
		3'(1 + sib_used_out + disp_bytes_out))
		else $error("consumed byte count mismatch");
	a_sp_base_seg: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(addr32_in && modrm_in[7:6] != 2'h3 && modrm_in[2:0] == 3'h4 &&
		sib_in[2:0] == 3'h4) |=> segment_out == EADEC_SEG_STACK)
		else $error("stack base lost stack segment");
	a_reg_width: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(width_in && data32_in) |=> rm_width_out == EADEC_OPW_LONG)
		else $error("long register width wrong");
	c_sib_form: cover property (@(posedge clk_in) state_r.sib_used &&
		state_r.disp_bytes == 3'h4);
	c_reg_form: cover property (@(posedge clk_in) state_r.is_reg &&
		state_r.rm_high);
	c_bp16: cover property (@(posedge clk_in) !state_r.sib_used &&
		state_r.segment == EADEC_SEG_STACK);
endmodule // effective_address_decoder

/* File: dv/eadec_prefetch_model.sv */
`timescale 1ns/1ps
module eadec_prefetch_model
(
	// Clock
	input  wire logic        clk_in,
	// Addressing bytes toward the decoder
	output logic             valid_out,
	output logic [7:0]       modrm_out,
	output logic [7:0]       sib_out,
	output logic [31:0]      disp_out,
	output logic             addr32_out,
	output logic             data32_out,
	output logic             width_out,
	output logic             done_out
);
	import eadec_pkg::*;
	logic   [12:0] n;
	logic   [31:0] r;
	integer        seed;
	initial
	begin
		seed = 11250;
		n = 13'h0;
		done_out = 1'b0;
		{valid_out, modrm_out, sib_out, disp_out} = '0;
		{addr32_out, data32_out, width_out} = 3'h0;
	end
	always @(negedge clk_in)
	begin
		r = $random(seed);
		valid_out = r[27];
		sib_out = r[23:16];
		disp_out = $random(seed);
		// Full sweep of byte and sizes first, then index-byte heavy mix
		if (n < 13'h800)
		begin
			modrm_out = n[7:0];
			{addr32_out, data32_out, width_out} = n[10:8];
		end
		else
		begin
			modrm_out = r[7:0];
			if (r[8])
				modrm_out[2:0] = 3'h4;
			{addr32_out, data32_out, width_out} = r[26:24];
		end
		if (sib_out[5:3] == EADEC_NO_INDEX)
			sib_out[7:6] = 2'h0;
		done_out = (n == 13'h16A8);
		n = n + 13'h1;
	end
endmodule // eadec_prefetch_model

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import eadec_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        v, a32, d32, w, done, vo, isr, sbo, beo, ieo;
	logic        rmh, fh;
	logic [7:0]  m, s, p_m, p_s;
	logic [31:0] d, p_d, dout;
	logic [2:0]  bro, iro, dbo, buo, rmr, fr;
	logic [1:0]  sco, sego;
	eadec_opw_e  rmw, fw;
	logic        p_v, p_a, p_dd, p_w;
	logic        p_r = 1'b1;
	int          miscompares = 0;
	int          n_compared = 0;
	always #12.5 clk_in = ~clk_in;
	eadec_prefetch_model eadec_prefetch_model_i (.clk_in(clk_in),
		.valid_out(v), .modrm_out(m), .sib_out(s), .disp_out(d),
		.addr32_out(a32), .data32_out(d32), .width_out(w), .done_out(done));
	effective_address_decoder effective_address_decoder_i (.clk_in(clk_in),
		.rst_in(rst_in), .valid_in(v), .modrm_in(m), .sib_in(s),
		.disp_in(d), .addr32_in(a32), .data32_in(d32), .width_in(w),
		.valid_out(vo), .is_reg_out(isr), .sib_used_out(sbo),
		.base_en_out(beo), .base_reg_out(bro), .index_en_out(ieo),
		.index_reg_out(iro), .scale_out(sco), .disp_bytes_out(dbo),
		.disp_out(dout), .segment_out(sego), .bytes_used_out(buo),
		.rm_reg_out(rmr), .rm_high_out(rmh), .rm_width_out(rmw),
		.field_reg_out(fr), .field_high_out(fh), .field_width_out(fw));
	always @(posedge clk_in)
		{p_v, p_m, p_s, p_d, p_a, p_dd, p_w, p_r} <=
			{v, m, s, d, a32, d32, w, rst_in};
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Byte registers fold onto codes 0..3 with a high-half flag
	function automatic logic [5:0] rmap(input logic [2:0] c);
		if (!p_w)
			return {1'b0, c[1:0], c[2], EADEC_OPW_BYTE};
		return {c, 1'b0, p_dd ? EADEC_OPW_LONG : EADEC_OPW_HALF};
	endfunction
	task automatic check_cycle();
		logic [1:0]  f;
		logic [2:0]  l, b, nd, br, ir;
		logic        sb, be, ie, stk;
		logic [31:0] dx;
		f = p_m[7:6];
		l = p_m[2:0];
		sb = p_a && f != 2'h3 && l == 3'h4;
		b = sb ? p_s[2:0] : l;
		if (f == 2'h3)
			nd = 3'h0;
		else if (f == 2'h1)
			nd = 3'h1;
		else if (f == 2'h2)
			nd = p_a ? 3'h4 : 3'h2;
		else if (p_a)
			nd = (b == 3'h5) ? 3'h4 : 3'h0;
		else
			nd = (l == 3'h6) ? 3'h2 : 3'h0;
		dx = (nd == 3'h1) ? {{24{p_d[7]}}, p_d[7:0]} :
			(nd == 3'h2) ? {16'h0, p_d[15:0]} : (nd == 3'h4) ? p_d : 32'h0;
		if (!p_a)
		begin
			// Lone SI or DI counts as the base, not the index
			be = !(l == 3'h6 && f == 2'h0);
			if (l == 3'h4)
				br = EADEC_REG_SI;
			else if (l == 3'h5)
				br = EADEC_REG_DI;
			else if (l == 3'h2 || l == 3'h3 || l == 3'h6)
				br = EADEC_REG_BP;
			else
				br = EADEC_REG_BX;
			ie = l < 3'h4;
			ir = l[0] ? EADEC_REG_DI : EADEC_REG_SI;
			stk = l == 3'h2 || l == 3'h3 || (l == 3'h6 && f != 2'h0);
		end
		else
		begin
			be = !(f == 2'h0 && b == 3'h5);
			br = b;
			ie = sb && p_s[5:3] != EADEC_NO_INDEX;
			ir = p_s[5:3];
			stk = (sb && b == 3'h4) || (b == 3'h5 && f != 2'h0);
		end
		be = be && f != 2'h3;
		ie = ie && f != 2'h3;
		cmp("valid", p_v, vo);
		cmp("is_reg", f == 2'h3, isr);
		cmp("sib_used", sb, sbo);
		cmp("base_en", be, beo);
		if (be)
			cmp("base_reg", br, bro);
		cmp("index_en", ie, ieo);
		if (ie)
			cmp("index_reg", ir, iro);
		if (sb)
			cmp("scale", p_s[7:6], sco);
		cmp("disp_bytes", nd, dbo);
		cmp("disp", dx, dout);
		if (f != 2'h3)
			cmp("segment", stk ? EADEC_SEG_STACK : EADEC_SEG_DATA, sego);
		cmp("bytes_used", 3'h1 + sb + nd, buo);
		if (f == 2'h3)
			cmp("rm_sel", rmap(l), {rmr, rmh, rmw});
		cmp("field_sel", rmap(p_m[5:3]), {fr, fh, fw});
	endtask
	always @(negedge clk_in)
		if (!p_r)
			check_cycle();
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#(25 * 8000);
		miscompares++;
		results();
	end
	initial
	begin
		repeat (3) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (3000) @(negedge clk_in);
		// Reset in mid-stream, decoding must resume at once
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		for (int i = 0; i < 5000 && done !== 1'b1; i++)
			@(negedge clk_in);
		// Model never finished: count as a failure
		if (done !== 1'b1)
			miscompares++;
		@(negedge clk_in);
		results();
	end
endmodule // testbench
